// ===== rtl/tpr_regbank.sv
// Purpose: Control and status register bank of the trigger processor, AHB-Lite slave.
// Assumes: Single CORE_CLK domain; datapath status and measurements synchronous to it.
// Notes:   Reads take one wait state, writes none; 16-bit registers in hwdata[15:0].
// Functional notes
// R1: Status 0 shows lane-up bits 11:0, channel-up of four payloads 15:12.
// R2: Status 1 bit 9 alignment complete, bit 8 test-mode sum error.
// R3: Status 1 bits 7:4 fiber link status, bit 3 history ready.
// R4: Status 1 bit 1 all six channels up; bits 2, 0 single payloads.
// R5: Payload enable bits 0..5 enable payloads one to six.
// R6: Link control bit 3 enables data alignment on sync falling edge.
// R7: Link control bit 2 fiber reset, bit 1 init transceivers, bit 0 arm history.
// R8: Sum threshold read/write, low half offset 8, high half offset 9.
// R9: History data readable, low half offset 10, high half offset 11.
// R10: History advances after high half read; read low half first.
// R11: Test control bits 0..2 reset sync, trigger1, trigger2 edge counters.
// R12: Offset 13 bits 7:0 give distribution clock frequency in MHz.
// R13: Offsets 14..16 hold 16-bit rising-edge counts of three distribution inputs.
// R14: Distribution board holds each counted pulse high at least 30 ns.
// R15: Build register bit 15 test build flag, bits 14:0 version.
// R16: Offset 18 holds crate identifier, read/write.
// R17: Rising edge of scaler control bit 14 latches timestamp and scalers.
// R18: With bit 15 set, that rising edge also clears the scalers.
// R19: Scaler control holds inhibit window 11:8 and calorimeter window 6:0.
// R20: Offset 20 holds 16-bit calorimeter threshold.
// R21: Offsets 21..24 hold low 16 threshold bits of scalers one to four.
// R22: Rising edges found by comparing written bit with stored value.
`timescale 1ns/1ps
`default_nettype none
`include "tpr_consts.svh"
module tpr_regbank import tpr_pkg::*; #(
   parameter logic TEST_BUILD = 1'b0,
   parameter logic [14:0] FW_VERSION = 15'h0001, // Arbitrary value
   parameter int COUNT_WIDTH = 16
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Datapath status
   input wire tpr_status_t STATUS,
   input wire logic [15:0] DIE_TEMP,
   input wire logic [15:0] VINT,
   input wire logic [7:0] DIST_CLK_MHZ,
   input wire logic [31:0] HIST_DATA,
   // Distribution board pins
   input wire logic SYNC_PIN,
   input wire logic FIRST_TRIGGER_INPUT,
   input wire logic SECOND_TRIGGER_INPUT,
   // Datapath control
   output tpr_ctrl_t CTRL,
   output logic HIST_ADVANCE,
   output logic SCALER_LATCH,
   output logic SCALER_CLEAR
);
   tpr_bus_state_t state_q;
   logic wr_pend_q;
   logic [4:0] wr_idx_q, rd_idx_q;
   logic wr_ok_q, rd_ok_q;
   logic addr_phase, addr_ok;
   logic [4:0] addr_idx;
   logic [15:0] wdata;
   logic [15:0] payload_en_q, link_ctrl_q, sum_lo_q, sum_hi_q, test_ctrl_q;
   logic [15:0] crate_q, scaler_ctrl_q, cal_thr_q;
   logic [15:0] scaler_thr_q [4];
   logic [15:0] rd_mux;
   logic [COUNT_WIDTH-1:0] edge_count [3];
   logic [2:0] edge_pins;
   logic [15:0] status_lo, status_hi;
   logic ctl_wr;
   logic latch_rise;

   // ==========================================
   // Address phase decode
   assign addr_phase = HSEL && HREADY && HTRANS[1];
   assign addr_idx = HADDR[6:2];
   // Anything beyond the map, or unaligned, reads zero and drops writes
   assign addr_ok = (HADDR[31:7] == 25'h0000000) && (HADDR[1:0] == 2'b00);
   assign wdata = HWDATA[15:0];

   // ==========================================
   // Bus state: reads stall one cycle so read data come from a flop
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state_q <= TPR_IDLE;
      end else begin
         case (state_q)
            TPR_IDLE: begin
               if (addr_phase && !HWRITE) begin
                  state_q <= TPR_RD_WAIT;
               end
            end
            TPR_RD_WAIT: begin
               state_q <= TPR_RD_DONE;
            end
            TPR_RD_DONE: begin
               if (addr_phase && !HWRITE) begin
                  state_q <= TPR_RD_WAIT;
               end else begin
                  state_q <= TPR_IDLE;
               end
            end
            default: begin
               state_q <= TPR_IDLE;
            end
         endcase
      end
   end

   assign HREADYOUT = (state_q != TPR_RD_WAIT);
   assign HRESP = 1'b0;

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 5'h00;
         wr_ok_q <= 1'b0;
         rd_idx_q <= 5'h00;
         rd_ok_q <= 1'b0;
      end else begin
         wr_pend_q <= addr_phase && HWRITE;
         if (addr_phase) begin
            wr_idx_q <= addr_idx;
            wr_ok_q <= addr_ok;
            rd_idx_q <= addr_idx;
            rd_ok_q <= addr_ok;
         end
      end
   end

   // Write data phase ends in the cycle after its address phase
   assign ctl_wr = wr_pend_q && wr_ok_q;

   // ==========================================
   // Read/write registers
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         payload_en_q <= `TPR_REG_RESET;
         link_ctrl_q <= `TPR_REG_RESET;
         sum_lo_q <= `TPR_REG_RESET;
         sum_hi_q <= `TPR_REG_RESET;
         test_ctrl_q <= `TPR_REG_RESET;
         crate_q <= `TPR_REG_RESET;
         scaler_ctrl_q <= `TPR_REG_RESET;
         cal_thr_q <= `TPR_REG_RESET;
         for (int i = 0; i < 4; i++) begin
            scaler_thr_q[i] <= `TPR_REG_RESET;
         end
      end else if (ctl_wr) begin
         case (wr_idx_q)
            `TPR_IDX_PAYLOAD_ENABLE: payload_en_q <= wdata; // R5
            `TPR_IDX_LINK_CONTROL: link_ctrl_q <= wdata; // R6 R7
            `TPR_IDX_SUM_THRESHOLD_LO: sum_lo_q <= wdata; // R8
            `TPR_IDX_SUM_THRESHOLD_HI: sum_hi_q <= wdata; // R8
            `TPR_IDX_TEST_COUNTER_CTRL: test_ctrl_q <= wdata; // R11
            `TPR_IDX_CRATE_IDENTIFIER: crate_q <= wdata; // R16
            `TPR_IDX_SCALER_WINDOW_CTRL: scaler_ctrl_q <= wdata; // R19
            `TPR_IDX_CALORIMETER_THRESH: cal_thr_q <= wdata; // R20
            `TPR_IDX_SCALER1_THRESH_LO: scaler_thr_q[0] <= wdata; // R21
            `TPR_IDX_SCALER2_THRESH_LO: scaler_thr_q[1] <= wdata; // R21
            `TPR_IDX_SCALER3_THRESH_LO: scaler_thr_q[2] <= wdata; // R21
            `TPR_IDX_SCALER4_THRESH_LO: scaler_thr_q[3] <= wdata; // R21
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // Scaler latch and clear: one pulse per zero-to-one write of bit 14
   assign latch_rise = ctl_wr && (wr_idx_q == `TPR_IDX_SCALER_WINDOW_CTRL)
                       && wdata[`TPR_BIT_SCALER_LATCH]
                       && !scaler_ctrl_q[`TPR_BIT_SCALER_LATCH]; // R22

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         SCALER_LATCH <= 1'b0;
         SCALER_CLEAR <= 1'b0;
      end else begin
         SCALER_LATCH <= latch_rise; // R17
         // New bit 15 of the same write counts, so one write can arm and fire
         SCALER_CLEAR <= latch_rise && wdata[`TPR_BIT_SCALER_CLEAR]; // R18
      end
   end

   // ==========================================
   // Edge counters on distribution board inputs
   assign edge_pins = {SECOND_TRIGGER_INPUT, FIRST_TRIGGER_INPUT, SYNC_PIN};

   // Counting relies on pulses of at least TPR_MIN_PULSE_CYC cycles
   generate
      for (genvar g = 0; g < 3; g++) begin : g_edge
         tpr_edge_counter #(
            .WIDTH(COUNT_WIDTH)
         ) u_cnt (
            .clk(CORE_CLK),
            .rst(SYS_RST),
            .pin(edge_pins[g]), // R14
            .clear(test_ctrl_q[g]), // R11
            .count(edge_count[g])
         );
      end
   endgenerate

   // ==========================================
   // Status words
   assign status_lo = {STATUS.chan_up[1], STATUS.chan_up[4], STATUS.chan_up[0],
                       STATUS.chan_up[2], STATUS.lane_up}; // R1
   assign status_hi = {6'h00, STATUS.alignment_complete, STATUS.sum_error, // R2
                       STATUS.fiber_ready, STATUS.fiber_remote_up,
                       STATUS.fiber_byte_align, STATUS.fiber_chan_align,
                       STATUS.hist_ready, // R3
                       STATUS.chan_up[5], &STATUS.chan_up, STATUS.chan_up[3]}; // R4

   // ==========================================
   // Read mux, sampled in the wait cycle
   always_comb begin
      rd_mux = 16'h0000;
      case (rd_idx_q)
         `TPR_IDX_LINK_STATUS_LO: rd_mux = status_lo;
         `TPR_IDX_LINK_STATUS_HI: rd_mux = status_hi;
         `TPR_IDX_PAYLOAD_ENABLE: rd_mux = payload_en_q;
         `TPR_IDX_LINK_CONTROL: rd_mux = link_ctrl_q;
         `TPR_IDX_DIE_TEMPERATURE: rd_mux = DIE_TEMP;
         `TPR_IDX_INTERNAL_VOLTAGE: rd_mux = VINT;
         `TPR_IDX_SUM_THRESHOLD_LO: rd_mux = sum_lo_q;
         `TPR_IDX_SUM_THRESHOLD_HI: rd_mux = sum_hi_q;
         `TPR_IDX_HISTORY_DATA_LO: rd_mux = HIST_DATA[15:0]; // R9
         `TPR_IDX_HISTORY_DATA_HI: rd_mux = HIST_DATA[31:16]; // R9
         `TPR_IDX_TEST_COUNTER_CTRL: rd_mux = test_ctrl_q;
         `TPR_IDX_DIST_CLOCK_FREQ: rd_mux = {8'h00, DIST_CLK_MHZ}; // R12
         `TPR_IDX_SYNC_EDGE_COUNT: rd_mux = 16'(edge_count[0]); // R13
         `TPR_IDX_FIRST_TRIGGER_INPUT_EDGE_COUNT: rd_mux = 16'(edge_count[1]); // R13
         `TPR_IDX_SECOND_TRIGGER_INPUT_EDGE_COUNT: rd_mux = 16'(edge_count[2]); // R13
         `TPR_IDX_BUILD_VERSION: rd_mux = {TEST_BUILD, FW_VERSION}; // R15
         `TPR_IDX_CRATE_IDENTIFIER: rd_mux = crate_q;
         `TPR_IDX_SCALER_WINDOW_CTRL: rd_mux = scaler_ctrl_q;
         `TPR_IDX_CALORIMETER_THRESH: rd_mux = cal_thr_q;
         `TPR_IDX_SCALER1_THRESH_LO: rd_mux = scaler_thr_q[0];
         `TPR_IDX_SCALER2_THRESH_LO: rd_mux = scaler_thr_q[1];
         `TPR_IDX_SCALER3_THRESH_LO: rd_mux = scaler_thr_q[2];
         `TPR_IDX_SCALER4_THRESH_LO: rd_mux = scaler_thr_q[3];
         default: rd_mux = 16'h0000;
      endcase
      if (!rd_ok_q) begin
         rd_mux = 16'h0000;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         HRDATA <= 32'h00000000;
      end else if (state_q == TPR_RD_WAIT) begin
         HRDATA <= {16'h0000, rd_mux};
      end
   end

   // ==========================================
   // History advance once the high half has been handed over
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         HIST_ADVANCE <= 1'b0;
      end else begin
         HIST_ADVANCE <= (state_q == TPR_RD_WAIT) && rd_ok_q
                         && (rd_idx_q == `TPR_IDX_HISTORY_DATA_HI); // R10
      end
   end

   // ==========================================
   // Control outputs
   always_comb begin
      CTRL.payload_en = payload_en_q[5:0]; // R5
      CTRL.align_en = link_ctrl_q[`TPR_BIT_ALIGN_EN]; // R6
      CTRL.fiber_reset = link_ctrl_q[`TPR_BIT_FIBER_RESET]; // R7
      CTRL.init_all = link_ctrl_q[`TPR_BIT_INIT_ALL]; // R7
      CTRL.hist_arm = link_ctrl_q[`TPR_BIT_HIST_ARM]; // R7
      CTRL.sum_threshold = {sum_hi_q, sum_lo_q}; // R8
      CTRL.crate_id = crate_q; // R16
      CTRL.inhibit_window = scaler_ctrl_q[`TPR_INHIBIT_MSB:`TPR_INHIBIT_LSB]; // R19
      CTRL.cal_window = scaler_ctrl_q[`TPR_CAL_WIN_MSB:0]; // R19
      CTRL.cal_threshold = cal_thr_q; // R20
      CTRL.scaler_thresh_lo = {scaler_thr_q[3], scaler_thr_q[2],
                               scaler_thr_q[1], scaler_thr_q[0]}; // R21
   end
endmodule // tpr_regbank
`default_nettype wire

// ===== rtl/tpr_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the register bank.
// Assumes: Word-aligned AHB-Lite access; byte address is four times the register index.
// Notes:   Definitions only.
`ifndef TPR_CONSTS_SVH
`define TPR_CONSTS_SVH

// ==========================================
// Register indices
`define TPR_IDX_LINK_STATUS_LO 5'h00
`define TPR_IDX_LINK_STATUS_HI 5'h01
`define TPR_IDX_PAYLOAD_ENABLE 5'h02
`define TPR_IDX_LINK_CONTROL 5'h03
`define TPR_IDX_DIE_TEMPERATURE 5'h04
`define TPR_IDX_INTERNAL_VOLTAGE 5'h05
`define TPR_IDX_SUM_THRESHOLD_LO 5'h08
`define TPR_IDX_SUM_THRESHOLD_HI 5'h09
`define TPR_IDX_HISTORY_DATA_LO 5'h0a
`define TPR_IDX_HISTORY_DATA_HI 5'h0b
`define TPR_IDX_TEST_COUNTER_CTRL 5'h0c
`define TPR_IDX_DIST_CLOCK_FREQ 5'h0d
`define TPR_IDX_SYNC_EDGE_COUNT 5'h0e
`define TPR_IDX_FIRST_TRIGGER_INPUT_EDGE_COUNT 5'h0f
`define TPR_IDX_SECOND_TRIGGER_INPUT_EDGE_COUNT 5'h10
`define TPR_IDX_BUILD_VERSION 5'h11
`define TPR_IDX_CRATE_IDENTIFIER 5'h12
`define TPR_IDX_SCALER_WINDOW_CTRL 5'h13
`define TPR_IDX_CALORIMETER_THRESH 5'h14
`define TPR_IDX_SCALER1_THRESH_LO 5'h15
`define TPR_IDX_SCALER2_THRESH_LO 5'h16
`define TPR_IDX_SCALER3_THRESH_LO 5'h17
`define TPR_IDX_SCALER4_THRESH_LO 5'h18

// ==========================================
// Field positions
`define TPR_BIT_ALIGN_EN 3
`define TPR_BIT_FIBER_RESET 2
`define TPR_BIT_INIT_ALL 1
`define TPR_BIT_HIST_ARM 0
`define TPR_BIT_SCALER_CLEAR 15
`define TPR_BIT_SCALER_LATCH 14
`define TPR_INHIBIT_MSB 11
`define TPR_INHIBIT_LSB 8
`define TPR_CAL_WIN_MSB 6
`define TPR_REG_RESET 16'h0000

// ==========================================
// Timing
`define TPR_CLK_MHZ 100
`define TPR_MIN_PULSE_NS 30
`define TPR_MIN_PULSE_CYC ((`TPR_MIN_PULSE_NS * `TPR_CLK_MHZ + 999) / 1000)

`endif

// ===== rtl/tpr_pkg.sv
// Purpose: Types shared by the register bank, its monitor and its testbench.
// Assumes: Datapath status arrives on the same clock.
// Notes:   Payload channel-up index is payload number minus one.
`default_nettype none
package tpr_pkg;
   typedef struct packed {
      logic [11:0] lane_up;
      logic [5:0] chan_up;
      logic fiber_ready;
      logic fiber_remote_up;
      logic fiber_byte_align;
      logic fiber_chan_align;
      logic hist_ready;
      logic alignment_complete;
      logic sum_error;
   } tpr_status_t;

   typedef struct packed {
      logic [5:0] payload_en;
      logic align_en;
      logic fiber_reset;
      logic init_all;
      logic hist_arm;
      logic [31:0] sum_threshold;
      logic [15:0] crate_id;
      logic [3:0] inhibit_window;
      logic [6:0] cal_window;
      logic [15:0] cal_threshold;
      logic [63:0] scaler_thresh_lo;
   } tpr_ctrl_t;

   typedef enum logic [1:0] {TPR_IDLE, TPR_RD_WAIT, TPR_RD_DONE} tpr_bus_state_t;
endpackage
`default_nettype wire

// ===== rtl/tpr_edge_counter.sv
// Purpose: Counts rising edges of one pin from the signal distribution board.
// Assumes: Pin is asynchronous to CORE_CLK; pulses held high long enough to sample twice.
// Notes:   Clear is a level and wins over a counted edge.
`timescale 1ns/1ps
`default_nettype none
module tpr_edge_counter #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pin and control
   input wire logic pin,
   input wire logic clear,
   // Result
   output logic [WIDTH-1:0] count
);
   logic s1_q, s2_q, s3_q, level_q;
   logic rise;

   // ==========================================
   // Synchroniser: change accepted once stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         level_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end

   assign rise = (s2_q == s3_q) && s3_q && !level_q;

   // ==========================================
   // Counter, wraps at full scale
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         count <= '0;
      end else if (rise) begin
         count <= count + WIDTH'(1); // R13
      end
   end
endmodule // tpr_edge_counter
`default_nettype wire

// ===== sim/tpr_regbank_monitor.sv
// Purpose: Concurrent checks on the ports of the register bank.
// Assumes: One clock, synchronous active-high reset, word transfers only.
// Notes:   Bound from the testbench top file; byte address is four times the index.
`timescale 1ns/1ps
`default_nettype none
module tpr_regbank_monitor import tpr_pkg::*; (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   // Bus
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   // Datapath
   input wire tpr_status_t STATUS,
   input wire tpr_ctrl_t CTRL,
   input wire logic HIST_ADVANCE,
   input wire logic SCALER_LATCH,
   input wire logic SCALER_CLEAR
);
   // ==========================================
   // Transfer decode
   logic acc;
   logic rd_acc;
   logic wr_acc;
   logic rd_hist;
   logic wr_win;
   logic wd14;
   logic wd15;
   logic [15:0] wd_lo;
   assign acc = HSEL & HREADY & HTRANS[1];
   assign rd_acc = acc & ~HWRITE;
   assign wr_acc = acc & HWRITE;
   assign rd_hist = rd_acc && HADDR == 32'h0000002c;
   assign wr_win = wr_acc && HADDR == 32'h0000004c;
   assign wd14 = HWDATA[14];
   assign wd15 = HWDATA[15];
   assign wd_lo = HWDATA[15:0];

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   // ==========================================
   // Bus timing
   a_resp_okay: assert property (HRESP == 1'b0) else $error("non-okay response");
   a_read_wait: assert property (rd_acc |=> !HREADYOUT ##1 HREADYOUT) else $error("read wait state wrong");
   a_write_nowait: assert property (wr_acc |=> HREADYOUT) else $error("write stalled");
   a_upper_zero: assert property (HRDATA[31:16] == 16'h0000) else $error("upper read bits set");

   // ==========================================
   // Status words, sampled while status holds still
   a_status_lo: assert property (rd_acc && HADDR == 32'h0 ##1 $stable(STATUS) ##1 $stable(STATUS)
      |-> HRDATA[15:0] == {STATUS.chan_up[1], STATUS.chan_up[4], STATUS.chan_up[0], STATUS.chan_up[2],
      STATUS.lane_up}) else $error("status low word wrong");
   a_status_hi: assert property (rd_acc && HADDR == 32'h4 ##1 $stable(STATUS) ##1 $stable(STATUS)
      |-> HRDATA[2:0] == {STATUS.chan_up[5], &STATUS.chan_up, STATUS.chan_up[3]})
      else $error("status high channel bits wrong");

   // ==========================================
   // Side effects
   a_hist_adv: assert property (rd_hist |-> ##2 HIST_ADVANCE) else $error("history did not advance");
   a_hist_cause: assert property (HIST_ADVANCE |-> $past(rd_hist, 2)) else $error("stray history advance");
   a_latch_cause: assert property (SCALER_LATCH |-> $past(wr_win, 2) && $past(wd14))
      else $error("stray scaler latch");
   a_clear_with: assert property (SCALER_CLEAR |-> SCALER_LATCH && $past(wd15))
      else $error("scaler clear without latch");
   a_crate_write: assert property (wr_acc && HADDR == 32'h48 |=> ##1 CTRL.crate_id == $past(wd_lo))
      else $error("crate id not stored");
   a_enable_write: assert property (wr_acc && HADDR == 32'h8 |=> ##1
      {10'h000, CTRL.payload_en} == ($past(wd_lo) & 16'h003f)) else $error("payload enables not stored");
endmodule // tpr_regbank_monitor
`default_nettype wire

// ===== sim/tpr_regbank_tb.sv
// Purpose: Self-checking bench for the register bank over AHB-Lite.
// Assumes: Reads take one wait state; the master still waits on ready.
// Notes:   Pulse outputs are counted by the bench and compared as deltas.
`timescale 1ns/1ps
`default_nettype none
`include "tpr_consts.svh"
module tpr_regbank_tb import tpr_pkg::*;;
   logic CORE_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic HSEL = 1'b0;
   logic HWRITE = 1'b0;
   logic [1:0] HTRANS = 2'b00;
   logic [31:0] HADDR = 32'h0;
   logic [31:0] HWDATA = 32'h0;
   tpr_status_t STATUS = '0;
   logic [15:0] DIE_TEMP = 16'h1357;
   logic [15:0] VINT = 16'h2468;
   logic [7:0] DIST_CLK_MHZ = 8'hfa;
   logic [31:0] HIST_DATA = 32'h1234abcd;
   logic [2:0] pins = 3'h0;
   wire logic [31:0] HRDATA;
   wire logic HREADYOUT;
   wire logic HRESP;
   wire tpr_ctrl_t CTRL;
   wire logic HIST_ADVANCE;
   wire logic SCALER_LATCH;
   wire logic SCALER_CLEAR;
   int failures = 0;
   int comparisons = 0;
   int n_adv = 0;
   int n_lat = 0;
   int n_clr = 0;

   tpr_regbank uut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'b010), .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .STATUS(STATUS), .DIE_TEMP(DIE_TEMP), .VINT(VINT),
      .DIST_CLK_MHZ(DIST_CLK_MHZ), .HIST_DATA(HIST_DATA), .SYNC_PIN(pins[0]), .FIRST_TRIGGER_INPUT(pins[1]),
      .SECOND_TRIGGER_INPUT(pins[2]), .CTRL(CTRL), .HIST_ADVANCE(HIST_ADVANCE), .SCALER_LATCH(SCALER_LATCH),
      .SCALER_CLEAR(SCALER_CLEAR));

   always #5 CORE_CLK = ~CORE_CLK;

   always @(posedge CORE_CLK) begin
      if (HIST_ADVANCE === 1'b1) n_adv++;
      if (SCALER_LATCH === 1'b1) n_lat++;
      if (SCALER_CLEAR === 1'b1) n_clr++;
   end

   // ==========================================
   // Bus and compare helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_ctrl(input tpr_ctrl_t got, input tpr_ctrl_t exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: control outputs %h expected %h", $time, got, exp);
      end
   endtask

   // Ready is sampled mid-cycle so the edge's own updates cannot race us
   task automatic wait_rdy(output logic [31:0] d);
      logic r;
      r = 1'b0;
      while (r !== 1'b1) begin
         @(negedge CORE_CLK);
         r = HREADYOUT;
         d = HRDATA;
         @(posedge CORE_CLK);
      end
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      HSEL <= 1'b1;
      HADDR <= a;
      HTRANS <= 2'b10;
      HWRITE <= wr;
      wait_rdy(rd);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= wd;
      wait_rdy(rd);
   endtask

   function automatic logic [31:0] ra(input logic [4:0] idx);
      return {25'h0, idx, 2'b00};
   endfunction

   task automatic wr(input logic [4:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, ra(idx), d, x);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check(x, exp);
   endtask

   task automatic pulse(input logic [2:0] m);
      pins <= m;
      repeat (3) @(posedge CORE_CLK);
      pins <= 3'h0;
      repeat (3) @(posedge CORE_CLK);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_regs();
      logic [4:0] idx [11] = '{5'h02, 5'h03, 5'h08, 5'h09, 5'h0c, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17};
      logic [15:0] p [32];
      tpr_ctrl_t e;
      for (int i = 0; i < 32; i++) p[i] = 16'hc35a ^ {i[4:0], i[4:0], i[4:0], 1'b1};
      p[24] = 16'h0f0f;
      for (int i = 0; i < 11; i++) wr(idx[i], {16'hffff, p[idx[i]]});
      wr(`TPR_IDX_SCALER4_THRESH_LO, {16'hffff, p[24]});
      for (int i = 0; i < 11; i++) rd_chk(ra(idx[i]), {16'h0, p[idx[i]]});
      e = '0;
      e.payload_en = p[2][5:0];
      {e.align_en, e.fiber_reset, e.init_all, e.hist_arm} = p[3][3:0];
      e.sum_threshold = {p[9], p[8]};
      e.crate_id = p[18];
      e.inhibit_window = p[19][11:8];
      e.cal_window = p[19][6:0];
      e.cal_threshold = p[20];
      e.scaler_thresh_lo = {p[24], p[23], p[22], p[21]};
      check_ctrl(CTRL, e);
   endtask

   task automatic t_ro();
      wr(`TPR_IDX_BUILD_VERSION, 32'h0000ffff);
      rd_chk(ra(`TPR_IDX_BUILD_VERSION), 32'h00000001);
      wr(5'h06, 32'h0000ffff);
      rd_chk(ra(5'h06), 32'h0);
      rd_chk(32'h00001008, 32'h0);
      rd_chk(ra(`TPR_IDX_DIE_TEMPERATURE), 32'h00001357);
      rd_chk(ra(`TPR_IDX_INTERNAL_VOLTAGE), 32'h00002468);
      rd_chk(ra(`TPR_IDX_DIST_CLOCK_FREQ), 32'h000000fa);
   endtask

   task automatic t_status(input tpr_status_t s);
      STATUS <= s;
      @(posedge CORE_CLK);
      rd_chk(ra(`TPR_IDX_LINK_STATUS_LO), {16'h0, s.chan_up[1], s.chan_up[4], s.chan_up[0], s.chan_up[2],
         s.lane_up});
      rd_chk(ra(`TPR_IDX_LINK_STATUS_HI), {22'h0, s.alignment_complete, s.sum_error, s.fiber_ready,
         s.fiber_remote_up, s.fiber_byte_align, s.fiber_chan_align, s.hist_ready, s.chan_up[5], &s.chan_up,
         s.chan_up[3]});
   endtask

   task automatic t_hist();
      int a;
      a = n_adv;
      rd_chk(ra(`TPR_IDX_HISTORY_DATA_LO), 32'h0000abcd);
      repeat (2) @(posedge CORE_CLK);
      check(32'(n_adv - a), 32'd0);
      rd_chk(ra(`TPR_IDX_HISTORY_DATA_HI), 32'h00001234);
      repeat (2) @(posedge CORE_CLK);
      check(32'(n_adv - a), 32'd1);
   endtask

   task automatic t_edges();
      wr(`TPR_IDX_TEST_COUNTER_CTRL, 32'h0);
      for (int i = 0; i < 3; i++) repeat (i + 1) pulse(3'b001 << i);
      repeat (8) @(posedge CORE_CLK);
      for (int i = 0; i < 3; i++) rd_chk(ra(`TPR_IDX_SYNC_EDGE_COUNT + i[4:0]), i + 1);
      wr(`TPR_IDX_TEST_COUNTER_CTRL, 32'h7);
      pulse(3'h7);
      repeat (8) @(posedge CORE_CLK);
      for (int i = 0; i < 3; i++) rd_chk(ra(`TPR_IDX_SYNC_EDGE_COUNT + i[4:0]), 32'h0);
      wr(`TPR_IDX_TEST_COUNTER_CTRL, 32'h0);
      pulse(3'h1);
      repeat (8) @(posedge CORE_CLK);
      rd_chk(ra(`TPR_IDX_SYNC_EDGE_COUNT), 32'h1);
   endtask

   task automatic t_latch();
      int l;
      int c;
      wr(`TPR_IDX_SCALER_WINDOW_CTRL, 32'h0);
      repeat (3) @(posedge CORE_CLK);
      l = n_lat;
      c = n_clr;
      wr(`TPR_IDX_SCALER_WINDOW_CTRL, 32'h4000);
      repeat (3) @(posedge CORE_CLK);
      check(32'(n_lat - l), 32'd1);
      check(32'(n_clr - c), 32'd0);
      wr(`TPR_IDX_SCALER_WINDOW_CTRL, 32'h4000);
      repeat (3) @(posedge CORE_CLK);
      check(32'(n_lat - l), 32'd1);
      wr(`TPR_IDX_SCALER_WINDOW_CTRL, 32'h0);
      wr(`TPR_IDX_SCALER_WINDOW_CTRL, 32'hc000);
      repeat (3) @(posedge CORE_CLK);
      check(32'(n_lat - l), 32'd2);
      check(32'(n_clr - c), 32'd1);
   endtask

   // ==========================================
   // Verdict and sequence
   task automatic print_verdict();
      if (failures == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge CORE_CLK);
      SYS_RST <= 1'b0;
      @(posedge CORE_CLK);
      check_ctrl(CTRL, '0);
      t_regs();
      t_ro();
      t_status(tpr_status_t'({12'h5a3, 6'h2d, 7'b1010110}));
      t_status(tpr_status_t'({12'ha5c, 6'h3f, 7'b0101001}));
      t_hist();
      t_edges();
      t_latch();
      print_verdict();
   end

   // Generous bound: the whole sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge CORE_CLK);
      failures++;
      $display("CHECK FAILED at %0t: timeout", $time);
      print_verdict();
   end
endmodule // tpr_regbank_tb

bind tpr_regbank tpr_regbank_monitor mon (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .STATUS(STATUS), .CTRL(CTRL), .HIST_ADVANCE(HIST_ADVANCE), .SCALER_LATCH(SCALER_LATCH),
   .SCALER_CLEAR(SCALER_CLEAR));
`default_nettype wire
